// ### hw/mcc_map.svh
/*
  Register offsets, field positions, reset values and encodings of the
  meter configuration handler. Assumes a classic Wishbone slave decoding
  full byte addresses, bits [7:0].
*/
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH
`define MCC_OFF_FUNC   8'h00
`define MCC_OFF_RANGE  8'h04
`define MCC_OFF_RES    8'h08
`define MCC_OFF_NPLC   8'h0C
`define MCC_OFF_APF    8'h10
`define MCC_OFF_APP    8'h14
`define MCC_OFF_FILT   8'h18
`define MCC_OFF_ZERO   8'h1C
`define MCC_OFF_HIZ    8'h20
`define MCC_OFF_MATH   8'h24
`define MCC_OFF_STAT   8'h28
`define MCC_OFF_ERR    8'h2C
`define MCC_OFF_TERM   8'h30
`define MCC_OFF_MNAME  8'h34
`define MCC_KW_POS     8
`define MCC_KW_VAL     2'h0
`define MCC_KW_MIN     2'h1
`define MCC_KW_MAX     2'h2
`define MCC_EN_POS     8
`define MCC_AR_DN_PCT  8'h0A
`define MCC_AR_UP_PCT  8'h78
`define MCC_RES_MAX    4'hF
`define MCC_RES_3HZ    4'h9
`define MCC_NPLC_MAX   3'h4
`define MCC_NPLC_RST   3'h3
`define MCC_APER_MAX   2'h2
`define MCC_APER_RST   2'h1
`define MCC_RES_RST    4'h4
`define MCC_HZ_SLOW    8'h03
`define MCC_HZ_MED     8'h14
`define MCC_HZ_FAST    8'hC8
`define MCC_ASCII_0    8'h30
`define MCC_STR_FRONT  32'h46524F4E
`define MCC_STR_REAR   32'h52454152
`define MCC_STR_NULL   32'h4E554C4C
`define MCC_STR_RDB    32'h00004442
`define MCC_STR_PDB    32'h0044424D
`define MCC_STR_AVER   32'h41564552
`define MCC_STR_LIM    32'h004C494D
`endif

// ### hw/mcc_pkg.sv
/*
  Types of the meter configuration handler.
  Assumes mcc_map.svh supplies the numeric constants.
*/
package mcc_pkg;
  typedef enum logic [3:0] {
    FN_DCV = 4'h0, FN_RATIO = 4'h1, FN_ACV = 4'h2, FN_DCI = 4'h3,
    FN_ACI = 4'h4, FN_OHM2 = 4'h5, FN_OHM4 = 4'h6, FN_FREQ = 4'h7,
    FN_PER = 4'h8, FN_CONT = 4'h9, FN_DIODE = 4'hA
  } mcc_func_type;
  typedef enum logic [2:0] {
    MO_NULL = 3'h0, MO_RDB = 3'h1, MO_PDB = 3'h2, MO_AVER = 3'h3, MO_LIM = 3'h4
  } mcc_math_type;
  typedef enum logic [1:0] {
    ZR_OFF = 2'h0, ZR_SINGLE_SHOT_CAL = 2'h1, ZR_ON = 2'h2
  } mcc_zero_type;
  typedef enum logic [1:0] {
    FL_SLOW = 2'h0, FL_MED = 2'h1, FL_FAST = 2'h2
  } mcc_filt_type;
endpackage

// ### hw/mcc_top.sv
/*
  Meter configuration handler: settings store behind a Wishbone slave,
  with autoranging, autozero requests and math validation.
  Assumes readings and trigger-wait state come from same-clock logic and
  the terminal switch comes from a pin.
*/
`timescale 1ns/1ps
`include "mcc_map.svh"
module mcc_top
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // measurement side
  input  wire logic                 reading_valid_i,
  input  wire logic [7:0]           reading_pct_i,
  input  wire logic                 wait_trig_i,
  input  wire logic                 rear_sel_i,
  // settings out
  output mcc_pkg::mcc_func_type     func_o,
  output logic      [2:0]           range_o,
  output logic                      autorange_o,
  output logic      [2:0]           integration_line_cycles_o,
  output mcc_pkg::mcc_filt_type     ac_filter_o,
  output logic                      autozero_on_o,
  output logic                      zero_now_o,
  output logic                      high_z_o,
  output mcc_pkg::mcc_math_type     math_op_select_o,
  output logic                      math_op_enable_o
);
  import mcc_pkg::*;

  mcc_func_type func_q;
  mcc_math_type op_q;
  mcc_zero_type zero_q;
  mcc_filt_type filt_q;
  logic [2:0]   range_q;
  logic         auto_q;
  logic [3:0]   res_q;
  logic [2:0]   nplc_q;
  logic [1:0]   apf_q;
  logic [1:0]   app_q;
  logic         hiz_q;
  logic         men_q;
  logic         err_rej_q;
  logic         err_conf_q;
  logic         ack_q;
  logic [31:0]  dat_q;
  logic         zero_now_q;
  logic         wait_q;
  logic [2:0]   rear_s_q;
  logic         rear_q;

  logic         wr;
  logic [1:0]   kw;
  logic         rej;
  logic         conf;
  logic         fn_chg;

  // highest range index per function
  function automatic logic [2:0] max_range(input mcc_func_type f);
    case (f)
      FN_DCI, FN_ACI:     max_range = 3'h3;
      FN_OHM2, FN_OHM4:   max_range = 3'h6;
      FN_CONT, FN_DIODE:  max_range = 3'h0;
      default:            max_range = 3'h4;
    endcase
  endfunction

  // math operation against function
  function automatic logic math_ok(input mcc_math_type o, input mcc_func_type f);
    case (o)
      MO_NULL:        math_ok = !(f inside {FN_CONT, FN_DIODE, FN_RATIO});
      MO_RDB, MO_PDB: math_ok = f inside {FN_DCV, FN_ACV};
      MO_AVER, MO_LIM: math_ok = !(f inside {FN_CONT, FN_DIODE});
      default:        math_ok = 1'b0;
    endcase
  endfunction

  function automatic logic nplc_ok(input mcc_func_type f);
    nplc_ok = f inside {FN_DCV, FN_RATIO, FN_DCI, FN_OHM2, FN_OHM4};
  endfunction

  // bus: one wait state, write lands as ack rises
  assign wr = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
  assign kw = dat_i[`MCC_KW_POS+1:`MCC_KW_POS];
  assign fn_chg = wr && adr_i == `MCC_OFF_FUNC && dat_i[3:0] <= 4'hA
                  && dat_i[3:0] != func_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= cyc_i && stb_i && !ack_q;
  end

  // acceptance checks per write
  always_comb
  begin
    rej  = 1'b0;
    conf = 1'b0;
    if (wr)
    begin
      case (adr_i)
        `MCC_OFF_FUNC:
          rej = dat_i[3:0] > 4'hA;
        `MCC_OFF_RANGE:
          rej = kw == `MCC_KW_VAL && dat_i[2:0] > max_range(func_q);
        `MCC_OFF_RES:
          rej = func_q inside {FN_FREQ, FN_PER, FN_RATIO};
        `MCC_OFF_NPLC:
          rej = !nplc_ok(func_q) || (kw == `MCC_KW_VAL && dat_i[2:0] > `MCC_NPLC_MAX);
        `MCC_OFF_APF, `MCC_OFF_APP:
          rej = kw == `MCC_KW_VAL && dat_i[1:0] > `MCC_APER_MAX;
        `MCC_OFF_FILT:
          rej = kw == `MCC_KW_VAL && !(dat_i[7:0] inside
                {`MCC_HZ_SLOW, `MCC_HZ_MED, `MCC_HZ_FAST});
        `MCC_OFF_ZERO:
          rej = dat_i[1:0] > 2'h2;
        `MCC_OFF_MATH:
        begin
          rej  = dat_i[2:0] > 3'h4;
          conf = !rej && men_q && math_ok(op_q, func_q)
                 && !math_ok(mcc_math_type'(dat_i[2:0]), func_q);
        end
        default:
          rej = 1'b0;
      endcase
    end
  end

  // function select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      func_q <= FN_DCV;
    else if (fn_chg)
      func_q <= mcc_func_type'(dat_i[3:0]);
  end

  // range and autorange
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      range_q <= 3'h0;
      auto_q  <= 1'b1;
    end
    else if (fn_chg)
      range_q <= max_range(mcc_func_type'(dat_i[3:0]));
    else if (wr && adr_i == `MCC_OFF_RANGE && !rej)
    begin
      auto_q <= dat_i[`MCC_EN_POS+2];
      case (kw)
        `MCC_KW_MIN: range_q <= 3'h0;
        `MCC_KW_MAX: range_q <= max_range(func_q);
        default:     range_q <= dat_i[2:0];
      endcase
    end
    else if (reading_valid_i && auto_q)
    begin
      if (reading_pct_i < `MCC_AR_DN_PCT && range_q != 3'h0)
        range_q <= range_q - 3'h1;
      else if (reading_pct_i > `MCC_AR_UP_PCT && range_q < max_range(func_q))
        range_q <= range_q + 3'h1;
    end
  end

  // resolution, integration time, gate times, filter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_q  <= `MCC_RES_RST;
      nplc_q <= `MCC_NPLC_RST;
      apf_q  <= `MCC_APER_RST;
      app_q  <= `MCC_APER_RST;
      filt_q <= FL_MED;
    end
    else if (wr && !rej)
    begin
      case (adr_i)
        `MCC_OFF_RES:
          res_q <= kw == `MCC_KW_MIN ? 4'h0 :
                   kw == `MCC_KW_MAX ? `MCC_RES_MAX : dat_i[3:0];
        `MCC_OFF_NPLC:
          nplc_q <= kw == `MCC_KW_MIN ? 3'h0 :
                    kw == `MCC_KW_MAX ? `MCC_NPLC_MAX : dat_i[2:0];
        `MCC_OFF_APF:
          apf_q <= kw == `MCC_KW_MIN ? 2'h0 :
                   kw == `MCC_KW_MAX ? `MCC_APER_MAX : dat_i[1:0];
        `MCC_OFF_APP:
          app_q <= kw == `MCC_KW_MIN ? 2'h0 :
                   kw == `MCC_KW_MAX ? `MCC_APER_MAX : dat_i[1:0];
        `MCC_OFF_FILT:
          if (kw == `MCC_KW_MIN || dat_i[7:0] == `MCC_HZ_SLOW)
            filt_q <= FL_SLOW;
          else if (kw == `MCC_KW_MAX || dat_i[7:0] == `MCC_HZ_FAST)
            filt_q <= FL_FAST;
          else
            filt_q <= FL_MED;
        default:
          res_q <= res_q;
      endcase
    end
  end

  // autozero mode and zero requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      zero_q     <= ZR_ON;
      zero_now_q <= 1'b0;
      wait_q     <= 1'b0;
    end
    else
    begin
      wait_q     <= wait_trig_i;
      zero_now_q <= 1'b0;
      if (wr && adr_i == `MCC_OFF_ZERO && !rej)
      begin
        if (dat_i[1:0] == 2'h1)
        begin
          zero_q     <= ZR_OFF;
          zero_now_q <= 1'b1;
        end
        else
          zero_q <= mcc_zero_type'(dat_i[1:0]);
      end
      else if (zero_q == ZR_OFF && wait_trig_i && !wait_q)
        zero_now_q <= 1'b1;
    end
  end

  // input resistance mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hiz_q <= 1'b0;
    else if (wr && adr_i == `MCC_OFF_HIZ)
      hiz_q <= dat_i[0];
  end

  // math select and enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_q  <= MO_NULL;
      men_q <= 1'b0;
    end
    else if (fn_chg)
      men_q <= 1'b0;
    else if (wr && adr_i == `MCC_OFF_MATH && !rej)
    begin
      op_q  <= mcc_math_type'(dat_i[2:0]);
      men_q <= dat_i[`MCC_EN_POS]
               && math_ok(mcc_math_type'(dat_i[2:0]), func_q);
    end
  end

  // error flags, write one to clear, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      err_rej_q  <= 1'b0;
      err_conf_q <= 1'b0;
    end
    else
    begin
      err_rej_q  <= rej || (err_rej_q
                    && !(wr && adr_i == `MCC_OFF_ERR && dat_i[0]));
      err_conf_q <= conf || (err_conf_q
                    && !(wr && adr_i == `MCC_OFF_ERR && dat_i[1]));
    end
  end

  // terminal pin, three stages, change once second and third agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rear_s_q <= 3'h0;
      rear_q   <= 1'b0;
    end
    else
    begin
      rear_s_q <= {rear_s_q[1:0], rear_sel_i};
      if (rear_s_q[1] == rear_s_q[2])
        rear_q <= rear_s_q[2];
    end
  end

  // read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0;
    else if (cyc_i && stb_i && !we_i && !ack_q)
    begin
      case (adr_i)
        `MCC_OFF_FUNC:  dat_q <= {28'h0, func_q};
        `MCC_OFF_RANGE: dat_q <= {21'h0, auto_q, 7'h0, range_q};
        `MCC_OFF_RES:   dat_q <= {28'h0, func_q inside {FN_FREQ, FN_PER}
                                  ? `MCC_RES_3HZ : res_q};
        `MCC_OFF_NPLC:  dat_q <= {29'h0, nplc_q};
        `MCC_OFF_APF:   dat_q <= {30'h0, apf_q};
        `MCC_OFF_APP:   dat_q <= {30'h0, app_q};
        `MCC_OFF_FILT:  dat_q <= {24'h0, filt_q == FL_SLOW ? `MCC_HZ_SLOW :
                                  filt_q == FL_FAST ? `MCC_HZ_FAST : `MCC_HZ_MED};
        `MCC_OFF_ZERO:  dat_q <= {30'h0, zero_q};
        `MCC_OFF_HIZ:   dat_q <= {31'h0, hiz_q};
        `MCC_OFF_MATH:  dat_q <= {23'h0, men_q, 5'h0, op_q};
        `MCC_OFF_STAT:  dat_q <= {`MCC_ASCII_0 | {7'h0, men_q},
                                  `MCC_ASCII_0 | {7'h0, hiz_q},
                                  `MCC_ASCII_0 | {7'h0, zero_q == ZR_ON},
                                  `MCC_ASCII_0 | {7'h0, auto_q}};
        `MCC_OFF_ERR:   dat_q <= {30'h0, err_conf_q, err_rej_q};
        `MCC_OFF_TERM:  dat_q <= rear_q ? `MCC_STR_REAR : `MCC_STR_FRONT;
        `MCC_OFF_MNAME:
          case (op_q)
            MO_RDB:  dat_q <= `MCC_STR_RDB;
            MO_PDB:  dat_q <= `MCC_STR_PDB;
            MO_AVER: dat_q <= `MCC_STR_AVER;
            MO_LIM:  dat_q <= `MCC_STR_LIM;
            default: dat_q <= `MCC_STR_NULL;
          endcase
        default:        dat_q <= 32'h0;
      endcase
    end
  end

  assign ack_o                     = ack_q;
  assign dat_o                     = dat_q;
  assign func_o                    = func_q;
  assign range_o                   = range_q;
  assign autorange_o               = auto_q;
  assign integration_line_cycles_o = nplc_q;
  assign ac_filter_o               = filt_q;
  assign autozero_on_o             = zero_q == ZR_ON;
  assign zero_now_o                = zero_now_q;
  assign high_z_o = hiz_q && func_q == FN_DCV && range_q <= 3'h2;
  assign math_op_select_o          = op_q;
  assign math_op_enable_o          = men_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence math_wr_s;
    wr && adr_i == `MCC_OFF_MATH;
  endsequence

  autorange_down_a: assert property (
    reading_valid_i && auto_q && !wr && reading_pct_i < `MCC_AR_DN_PCT
    && range_q != 3'h0 |=> range_q == $past(range_q) - 3'h1)
    else $error("autorange did not step down");
  autorange_up_a: assert property (
    reading_valid_i && auto_q && !wr && reading_pct_i > `MCC_AR_UP_PCT
    && range_q < max_range(func_q) |=> range_q == $past(range_q) + 3'h1)
    else $error("autorange did not step up");
  res_reject_a: assert property (
    wr && adr_i == `MCC_OFF_RES && func_q inside {FN_FREQ, FN_PER, FN_RATIO}
    |=> $stable(res_q) && err_rej_q)
    else $error("resolution accepted for wrong function");
  nplc_reject_a: assert property (
    wr && adr_i == `MCC_OFF_NPLC && !nplc_ok(func_q) |=> $stable(nplc_q))
    else $error("integration time accepted for wrong function");
  zero_single_shot_cal_a: assert property (
    wr && adr_i == `MCC_OFF_ZERO && dat_i[1:0] == 2'h1
    |=> zero_now_o && zero_q == ZR_OFF ##1 !zero_now_o)
    else $error("single-shot zero misbehaved");
  zero_wait_a: assert property (
    zero_now_o |-> ($past(zero_q) == ZR_OFF && $past(wait_trig_i && !wait_q))
    || $past(wr && adr_i == `MCC_OFF_ZERO && dat_i[1:0] == 2'h1))
    else $error("zero request without cause");
  math_fn_clear_a: assert property (
    fn_chg |=> !math_op_enable_o)
    else $error("math survived a function change");
  math_compat_a: assert property (
    math_op_enable_o |-> math_ok(op_q, func_q))
    else $error("incompatible math op enabled");
  math_conflict_a: assert property (
    math_wr_s ##0 (men_q && math_ok(op_q, func_q) && dat_i[2:0] <= 3'h4
    && !math_ok(mcc_math_type'(dat_i[2:0]), func_q)) |=> err_conf_q && !men_q)
    else $error("conflict not posted");
  high_z_range_a: assert property (
    high_z_o |-> hiz_q && range_q < 3'h3)
    else $error("high input resistance on wrong range");
  bus_ack_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("wishbone ack timing broken");
endmodule

// ### tb/mcc_front_model.sv
/*
  Behavioural measurement front end: reading strobes, trigger-wait level
  and terminal switch pin for the meter configuration handler.
  Assumes the bench asks for a reading with a one-cycle fire strobe.
*/
`timescale 1ns/1ps
module mcc_front_model
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bench requests
  input  wire logic       fire_i,
  input  wire logic [7:0] pct_i,
  input  wire logic       arm_i,
  input  wire logic       rear_i,
  // toward the handler
  output logic            reading_valid_o,
  output logic [7:0]      reading_pct_o,
  output logic            wait_trig_o,
  output logic            rear_sel_o
);
  initial
  begin
    reading_valid_o = 1'b0;
    reading_pct_o   = 8'hA5;
    wait_trig_o     = 1'b0;
    rear_sel_o      = 1'b0;
  end
  // value only means something with its strobe, scrambled otherwise
  always @(posedge clk_i)
  begin
    reading_valid_o <= fire_i & ~rst_i;
    reading_pct_o   <= fire_i ? pct_i : ~reading_pct_o;
    wait_trig_o     <= arm_i & ~rst_i;
    rear_sel_o      <= rear_i;
  end
endmodule

// ### tb/mcc_top_test.sv
/*
  Self-checking bench of the meter configuration handler: Wishbone host
  tasks, expectation functions, random autorange readings.
  Assumes mcc_pkg and mcc_front_model are compiled first.
*/
`timescale 1ns/1ps
`include "mcc_map.svh"
module mcc_top_test;
  import mcc_pkg::*;
  localparam int          LIMIT = 20000;
  localparam logic [31:0] KMIN  = 32'h00000100;
  localparam logic [31:0] KMAX  = 32'h00000200;
  localparam logic [31:0] AUTO  = 32'h00000400;
  localparam logic [31:0] MEN   = 32'h00000100;
  localparam logic [7:0]  HAND [4] = '{8'd10, 8'd9, 8'd120, 8'd121};
  localparam logic [7:0]  HZ [4]   = '{8'h03, 8'h14, 8'hC8, 8'h07};
  localparam mcc_filt_type FLT [3] = '{FL_SLOW, FL_MED, FL_FAST};
  localparam logic [3:0]  NORES [3] = '{FN_FREQ, FN_PER, FN_RATIO};
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i  = 1'b0;
  logic [7:0]   adr_i = 8'h00;
  logic [3:0]   sel_i = 4'h0;
  logic [31:0]  dat_i = 32'h0;
  logic [31:0]  dat_o;
  logic         ack_o;
  logic         reading_valid_i;
  logic [7:0]   reading_pct_i;
  logic         wait_trig_i;
  logic         rear_sel_i;
  mcc_func_type func_o;
  logic [2:0]   range_o;
  logic         autorange_o;
  logic [2:0]   integration_line_cycles_o;
  mcc_filt_type ac_filter_o;
  logic         autozero_on_o;
  logic         zero_now_o;
  logic         high_z_o;
  mcc_math_type math_op_select_o;
  logic         math_op_enable_o;
  logic         fire = 1'b0;
  logic [7:0]   pct  = 8'h00;
  logic         arm  = 1'b0;
  logic         rear = 1'b0;
  logic [31:0]  rv;
  logic [31:0]  seed = 32'h0B63DFE1;
  logic [7:0]   p;
  logic [2:0]   e;
  logic         ok;
  logic         en;
  int           j;
  int           z0;
  int           nz      = 0;
  int           cyc_n   = 0;
  int           fails   = 0;
  int           n_tests = 0;

  mcc_top dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .reading_valid_i(reading_valid_i), .reading_pct_i(reading_pct_i),
    .wait_trig_i(wait_trig_i), .rear_sel_i(rear_sel_i), .func_o(func_o),
    .range_o(range_o), .autorange_o(autorange_o),
    .integration_line_cycles_o(integration_line_cycles_o),
    .ac_filter_o(ac_filter_o), .autozero_on_o(autozero_on_o),
    .zero_now_o(zero_now_o), .high_z_o(high_z_o),
    .math_op_select_o(math_op_select_o), .math_op_enable_o(math_op_enable_o)
  );
  mcc_front_model front
  (
    .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .pct_i(pct), .arm_i(arm),
    .rear_i(rear), .reading_valid_o(reading_valid_i),
    .reading_pct_o(reading_pct_i), .wait_trig_o(wait_trig_i),
    .rear_sel_o(rear_sel_i)
  );

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (zero_now_o === 1'b1)
      nz <= nz + 1;

  function automatic logic [2:0] rmax(input logic [3:0] f);
    case (f)
      FN_DCI, FN_ACI: return 3'h3;
      FN_OHM2, FN_OHM4: return 3'h6;
      FN_CONT, FN_DIODE: return 3'h0;
      default: return 3'h4;
    endcase
  endfunction
  function automatic logic mok(input logic [3:0] f, input logic [2:0] m);
    case (m)
      MO_NULL: return !(f inside {FN_RATIO, FN_CONT, FN_DIODE});
      MO_RDB, MO_PDB: return f inside {FN_DCV, FN_ACV};
      default: return !(f inside {FN_CONT, FN_DIODE});
    endcase
  endfunction
  function automatic logic [31:0] mname(input logic [2:0] m);
    case (m)
      MO_RDB: return `MCC_STR_RDB;
      MO_PDB: return `MCC_STR_PDB;
      MO_AVER: return `MCC_STR_AVER;
      MO_LIM: return `MCC_STR_LIM;
      default: return `MCC_STR_NULL;
    endcase
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    // only the bench timeout ends a missing answer
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic err(input logic [1:0] x);
    rd(`MCC_OFF_ERR);
    chk(rv[1:0], x);
    wr(`MCC_OFF_ERR, 32'h3);
  endtask
  task automatic rdg(input logic [7:0] v);
    @(posedge clk_i);
    fire <= 1'b1;
    pct  <= v;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic close_out;
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(func_o, FN_DCV);
    chk(autorange_o, 1'b1);
    chk(integration_line_cycles_o, `MCC_NPLC_RST);
    chk(ac_filter_o, FL_MED);
    chk(autozero_on_o, 1'b1);
    chk({math_op_enable_o, math_op_select_o}, {1'b0, MO_NULL});
    rd(`MCC_OFF_STAT);
    chk(rv, 32'h30303131);
    for (int f = 0; f <= 10; f++)
    begin
      wr(`MCC_OFF_FUNC, f);
      chk(func_o, f);
      wr(`MCC_OFF_RANGE, KMIN);
      chk(range_o, 3'h0);
      wr(`MCC_OFF_RANGE, KMAX);
      chk(range_o, rmax(f[3:0]));
    end
    wr(`MCC_OFF_FUNC, 32'hB);
    chk(func_o, FN_DIODE);
    err(2'h1);
    // autorange: corners first, then random readings
    wr(`MCC_OFF_FUNC, FN_DCV);
    wr(`MCC_OFF_RANGE, AUTO | 32'h2);
    e = 3'h2;
    for (int i = 0; i < 28; i++)
    begin
      seed = nx(seed);
      p = (i < 4) ? HAND[i] : seed[7:0] % 8'd160;
      rdg(p);
      if (p < `MCC_AR_DN_PCT && e > 3'h0)
        e--;
      else if (p > `MCC_AR_UP_PCT && e < rmax(FN_DCV))
        e++;
      chk(range_o, e);
    end
    wr(`MCC_OFF_RANGE, 32'h2);
    rdg(8'd5);
    chk(range_o, 3'h2);
    rd(`MCC_OFF_STAT);
    chk(rv[7:0], `MCC_ASCII_0);
    wr(`MCC_OFF_RES, KMAX);
    rd(`MCC_OFF_RES);
    chk(rv[3:0], `MCC_RES_MAX);
    wr(`MCC_OFF_RES, KMIN);
    rd(`MCC_OFF_RES);
    chk(rv[3:0], 4'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(`MCC_OFF_FUNC, NORES[i]);
      wr(`MCC_OFF_RES, 32'h2);
      err(2'h1);
      rd(`MCC_OFF_RES);
      if (i < 2)
        chk(rv[3:0], `MCC_RES_3HZ);
    end
    for (int f = 0; f <= 10; f++)
    begin
      wr(`MCC_OFF_FUNC, f);
      ok = f[3:0] inside {FN_DCV, FN_RATIO, FN_DCI, FN_OHM2, FN_OHM4};
      wr(`MCC_OFF_NPLC, ok ? KMIN : KMAX);
      err({1'b0, !ok});
      if (ok)
        chk(integration_line_cycles_o, 3'h0);
    end
    wr(`MCC_OFF_FUNC, FN_DCV);
    for (int v = 0; v <= 5; v++)
    begin
      wr(`MCC_OFF_NPLC, v);
      chk(integration_line_cycles_o, v < 5 ? v : 4);
    end
    err(2'h1);
    for (int g = 0; g <= 3; g++)
    begin
      wr(`MCC_OFF_APF, g);
      rd(`MCC_OFF_APF);
      chk(rv[1:0], g < 3 ? g : 2);
    end
    err(2'h1);
    rd(`MCC_OFF_APP);
    chk(rv[1:0], `MCC_APER_RST);
    wr(`MCC_OFF_APP, KMAX);
    rd(`MCC_OFF_APP);
    chk(rv[1:0], `MCC_APER_MAX);
    for (int i = 0; i < 4; i++)
    begin
      j = (i < 3) ? i : 2;
      wr(`MCC_OFF_FILT, HZ[i]);
      rd(`MCC_OFF_FILT);
      chk(rv[7:0], HZ[j]);
      chk(ac_filter_o, FLT[j]);
    end
    wr(`MCC_OFF_FILT, KMIN);
    chk(ac_filter_o, FL_SLOW);
    wr(`MCC_OFF_FILT, KMAX);
    chk(ac_filter_o, FL_FAST);
    err(2'h1);
    z0 = nz;
    wr(`MCC_OFF_ZERO, ZR_SINGLE_SHOT_CAL);
    repeat (4) @(posedge clk_i);
    chk(nz - z0, 1);
    chk(autozero_on_o, 1'b0);
    z0 = nz;
    repeat (6) @(posedge clk_i);
    arm <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(nz - z0, 1);
    arm <= 1'b0;
    wr(`MCC_OFF_ZERO, ZR_ON);
    chk(autozero_on_o, 1'b1);
    z0 = nz;
    wr(`MCC_OFF_ZERO, ZR_OFF);
    repeat (3) @(posedge clk_i);
    chk(nz - z0, 0);
    chk(autozero_on_o, 1'b0);
    wr(`MCC_OFF_HIZ, 32'h1);
    for (int r = 0; r <= 4; r++)
    begin
      wr(`MCC_OFF_RANGE, r);
      chk(high_z_o, r <= 2);
    end
    wr(`MCC_OFF_FUNC, FN_ACV);
    wr(`MCC_OFF_RANGE, 32'h0);
    chk(high_z_o, 1'b0);
    for (int t = 0; t < 2; t++)
    begin
      rear <= t[0];
      repeat (6) @(posedge clk_i);
      rd(`MCC_OFF_TERM);
      chk(rv, t ? `MCC_STR_REAR : `MCC_STR_FRONT);
    end
    for (int f = 0; f <= 10; f++)
    begin
      wr(`MCC_OFF_FUNC, f);
      chk(math_op_enable_o, 1'b0);
      en = 1'b0;
      for (int m = 0; m <= 4; m++)
      begin
        ok = mok(f[3:0], m[2:0]);
        wr(`MCC_OFF_MATH, MEN | m);
        chk(math_op_enable_o, ok);
        chk(math_op_select_o, m);
        err({en & !ok, 1'b0});
        rd(`MCC_OFF_MNAME);
        chk(rv, mname(m[2:0]));
        en = ok;
      end
    end
    wr(`MCC_OFF_FUNC, FN_DCV);
    wr(`MCC_OFF_MATH, MEN | MO_AVER);
    chk(math_op_enable_o, 1'b1);
    rd(`MCC_OFF_STAT);
    chk(rv[31:24], 8'h31);
    wr(`MCC_OFF_MATH, MO_AVER);
    chk(math_op_enable_o, 1'b0);
    // remote reset in mid-run drops math and function
    wr(`MCC_OFF_FUNC, FN_ACV);
    wr(`MCC_OFF_MATH, MEN | MO_LIM);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({math_op_enable_o, math_op_select_o}, {1'b0, MO_NULL});
    chk(func_o, FN_DCV);
    close_out();
  end
endmodule
